/* hw/mfbc_top.sv */
// Purpose: motor short supervision, power-stage gating and brake output
// Assumes: all inputs but the async NRST synchronous to REF_CLK; plain register port
// Notes:   brake release on the mapped output is active high
//
// Contract
// RULE1: phase-to-phase shorts are supervised all the time.
// RULE2: phase-to-ground shorts are supervised unless the variant lacks it.
// RULE3: dc bus, braking resistor and brake wire shorts are not detected.
// RULE4: a detected short disables the power stage at once.
// RULE5: a detected short records and reports the over-current fault code.
// RULE6: once the cause is gone the operator may request re-enable.
// RULE7: after three failed resets in a row, resets are refused a minute.
// RULE8: the brake function sits on at most one of four outputs.
// RULE9: the brake is released while enabled and applied when disabled.
// RULE10: the default brake mapping is the fourth output or none by mode.
// RULE11: writing 10 to factory reset restores default output mapping.
// RULE12: a mode change may reset mapping to the new mode's defaults.
// RULE13: with the keep digit at 0 the mapping survives a mode change.
// RULE14: the fail count clears on success or when the lockout ends.
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module mfbc_top #(
  parameter longint LOCK_CYCLES  = mfbc_pkg::LOCKOUT_CYCLES,
  parameter logic   GND_CHECK    = 1'b1,
  // modes whose default puts the brake function on the fourth output
  parameter logic [15:0] BRAKE_MODES = 16'h00FF
) (
  input  wire logic                  REF_CLK,
  input  wire logic                  NRST,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  input  wire logic [3:0]            REG_ADDR,
  input  wire logic [31:0]           REG_WDATA,
  output logic      [31:0]           REG_RDATA,
  input  wire mfbc_pkg::mfbc_sense_t SHORT_SENSE,
  input  wire logic                  MODE_SWITCH_POSITION_INPUT,
  input  wire logic [3:0]            MODE_SWITCH_VALUE,
  output logic                       POWER_STAGE_EN,
  output logic [3:0]                 DIGITAL_OUTPUT,
  output logic [7:0]                 FAULT_CODE
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_ON    = 2'b01,
    ST_FAULT = 2'b10
  } mfbc_pst_t;

  typedef struct packed {
    mfbc_pst_t   pst;
    logic [7:0]  fault;
    logic [2:0]  brake_map;
    logic [3:0]  other_do;
    logic [4:0]  mode;
    logic        gnd_chk;
    logic [31:0] rdata;
  } mfbc_state_t;

  mfbc_state_t s_q;
  mfbc_state_t s_d;

  mfbc_pkg::mfbc_bus_t bus;
  logic       trip;
  logic       locked;
  logic [1:0] fail_cnt;
  logic       en_req;
  logic       reset_fail;
  logic       reset_ok;
  logic       mode_chg;
  logic [3:0] new_mode;
  logic [2:0] def_map;
  logic [3:0] brake_vec;
  logic       wr_ctrl;
  logic       wr_map;
  logic       wr_freset;
  logic       wr_mode;
  logic       freset_ok;
  logic       stop_req;
  logic [3:0] brake_sel;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] map_word;
  logic [31:0] mode_word;
  logic [31:0] fault_word;

  assign bus.wr    = REG_WR;
  assign bus.rd    = REG_RD;
  assign bus.addr  = REG_ADDR;
  assign bus.wdata = REG_WDATA;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  // one write strobe per writable register, shared by all next-state logic
  assign wr_ctrl   = bus.wr && (bus.addr == mfbc_pkg::ADDR_CTRL);
  assign wr_map    = bus.wr && (bus.addr == mfbc_pkg::ADDR_MAP);
  assign wr_freset = bus.wr && (bus.addr == mfbc_pkg::ADDR_FRESET);
  assign wr_mode   = bus.wr && (bus.addr == mfbc_pkg::ADDR_MODE);
  // only the restore value in the low byte acts; the upper bits are not compared
  assign freset_ok = wr_freset
                     && (bus.wdata[7:0] == mfbc_pkg::FRESET_MAGIC); // RULE11
  // a control write with the enable bit low switches the stage off
  assign stop_req  = wr_ctrl && !bus.wdata[mfbc_pkg::CTRL_ENABLE_BIT];

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  mfbc_short_det u_det (
    .clk        (REF_CLK),
    .rst_n      (NRST),
    .sense      (SHORT_SENSE),
    .gnd_chk_en (s_q.gnd_chk),
    .trip       (trip)
  );

  mfbc_lockout #(
    .LOCK_CYCLES (LOCK_CYCLES)
  ) u_lock (
    .clk      (REF_CLK),
    .rst_n    (NRST),
    .fail     (reset_fail),
    .success  (reset_ok),
    .locked   (locked),
    .fail_cnt (fail_cnt)
  );

  // ----------------------------------------------------------------
  // enable request and its outcome
  // ----------------------------------------------------------------
  // an enable write is the operator's re-enable request
  assign en_req = wr_ctrl && bus.wdata[mfbc_pkg::CTRL_ENABLE_BIT]; // RULE6
  // a request in fault while the short persists counts as a failed reset; requests while locked do not
  assign reset_fail = en_req && !locked
                      && (s_q.pst == ST_FAULT) && trip; // RULE7
  assign reset_ok   = en_req && !locked && !trip
                      && (s_q.pst != ST_ON); // RULE14

  // mode change from register or mode-switch input
  always_comb begin
    mode_chg = 1'b0;
    new_mode = s_q.mode[3:0];
    if (wr_mode) begin
      mode_chg = (bus.wdata[3:0] != s_q.mode[3:0]);
      new_mode = bus.wdata[3:0];
    end else if (MODE_SWITCH_POSITION_INPUT) begin
      mode_chg = (MODE_SWITCH_VALUE != s_q.mode[3:0]);
      new_mode = MODE_SWITCH_VALUE;
    end
  end

  // default mapping: fourth output or unassigned, per mode
  // one place decides the factory mapping, so restore and mode change agree
  function automatic logic [2:0] factory_map(input logic [3:0] md);
    logic [2:0] m;
    m = mfbc_pkg::MAP_NONE;
    if (BRAKE_MODES[md]) begin
      m = mfbc_pkg::MAP_FOURTH;
    end
    return m;
  endfunction

  assign def_map = factory_map(new_mode); // RULE10

  // ----------------------------------------------------------------
  // read words
  // ----------------------------------------------------------------
  // each word is built field by field; unused bits read as zero
  always_comb begin
    ctrl_word   = 32'h0;
    status_word = 32'h0;
    map_word    = 32'h0;
    mode_word   = 32'h0;
    fault_word  = 32'h0;
    ctrl_word[mfbc_pkg::CTRL_ENABLE_BIT]  = (s_q.pst == ST_ON);
    ctrl_word[mfbc_pkg::CTRL_GND_CHK_BIT] = s_q.gnd_chk;
    // live trip beside the latched fault, so software sees the cause go
    status_word[0]   = (s_q.pst == ST_FAULT);
    status_word[1]   = trip;
    status_word[2]   = locked;
    status_word[4:3] = fail_cnt;
    map_word[2:0]    = s_q.brake_map;
    map_word[11:8]   = s_q.other_do;
    mode_word[4:0]   = s_q.mode;
    fault_word[7:0]  = s_q.fault;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.gnd_chk = GND_CHECK; // RULE2

    case (s_q.pst)
      ST_OFF: begin
        if (reset_ok) begin
          s_d.pst = ST_ON;
        end
      end
      ST_ON: begin
        if (stop_req) begin
          s_d.pst = ST_OFF;
        end
      end
      ST_FAULT: begin
        if (reset_ok) begin
          s_d.pst   = ST_ON; // RULE6
          s_d.fault = mfbc_pkg::FAULT_NONE;
        end
      end
      default: begin
        s_d.pst = ST_OFF;
      end
    endcase

    // a short overrides every power-state and fault-code change, even a same-cycle enable
    if (trip) begin
      s_d.pst   = ST_FAULT; // RULE4
      s_d.fault = mfbc_pkg::OVERCURRENT_CODE; // RULE5
    end

    // brake mapping: value 1..4 selects one output, others unassigned
    if (wr_map) begin
      s_d.brake_map = (bus.wdata[2:0] > 3'h4) ? mfbc_pkg::MAP_NONE
                                              : bus.wdata[2:0]; // RULE8
      s_d.other_do  = bus.wdata[11:8];
    end

    // restore wins over a plain mapping write in the same cycle
    if (freset_ok) begin
      s_d.brake_map = factory_map(s_q.mode[3:0]); // RULE11
      s_d.other_do  = 4'h0; // RULE11
    end

    if (wr_mode) begin
      s_d.mode[mfbc_pkg::MODE_KEEP_BIT] = bus.wdata[mfbc_pkg::MODE_KEEP_BIT];
    end
    if (mode_chg) begin
      s_d.mode[3:0] = new_mode;
      // keep digit is taken from the same write when there is one
      if (s_d.mode[mfbc_pkg::MODE_KEEP_BIT]) begin
        s_d.brake_map = def_map; // RULE12
        s_d.other_do  = 4'h0; // RULE12
      end // RULE13
    end

    // read data stands one cycle after the strobe
    s_d.rdata = 32'h0;
    if (bus.rd) begin
      case (bus.addr)
        mfbc_pkg::ADDR_CTRL: begin
          s_d.rdata = ctrl_word;
        end
        mfbc_pkg::ADDR_STATUS: begin
          s_d.rdata = status_word;
        end
        mfbc_pkg::ADDR_MAP: begin
          s_d.rdata = map_word;
        end
        mfbc_pkg::ADDR_MODE: begin
          s_d.rdata = mode_word;
        end
        mfbc_pkg::ADDR_FAULT: begin
          s_d.rdata = fault_word; // RULE5
        end
        default: begin
          s_d.rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      s_q.pst       <= ST_OFF;
      s_q.fault     <= mfbc_pkg::FAULT_NONE;
      // reset mapping follows the reset mode's factory default
      s_q.brake_map <= BRAKE_MODES[mfbc_pkg::MODE_RESET] ? mfbc_pkg::MAP_FOURTH
                                                         : mfbc_pkg::MAP_NONE;
      s_q.other_do  <= 4'h0;
      s_q.mode      <= mfbc_pkg::MODE_REG_RESET;
      s_q.gnd_chk   <= 1'b0;
      s_q.rdata     <= 32'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // shorts to dc bus, brake resistor or brake wires have no sense input
  // RULE3
  // the trip gates the stage combinationally so no cycle is lost
  assign POWER_STAGE_EN = (s_q.pst == ST_ON) && !trip; // RULE4

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_do
      // one compare per pin, so the function can sit on one output only
      assign brake_sel[gi] = (s_q.brake_map == 3'(gi + 1)); // RULE8
      assign brake_vec[gi] = brake_sel[gi] && POWER_STAGE_EN; // RULE9
      // the brake output wins over the general-purpose value on its pin
      assign DIGITAL_OUTPUT[gi] = brake_sel[gi] ? brake_vec[gi]
                                                : s_q.other_do[gi];
    end
  endgenerate

  assign FAULT_CODE = s_q.fault; // RULE5
  assign REG_RDATA  = s_q.rdata;
endmodule
`default_nettype wire

/* hw/mfbc_pkg.sv */
// Purpose: shared constants and carriers for the motor fault and brake block
// Assumes: 250 MHz clock, register port with one-cycle read latency
// Notes:   offsets are word indices on the plain register port
package mfbc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MAP    = 4'h2;
  localparam logic [3:0] ADDR_FRESET = 4'h3;
  localparam logic [3:0] ADDR_MODE   = 4'h4;
  localparam logic [3:0] ADDR_FAULT  = 4'h5;

  // ctrl bits
  localparam int CTRL_ENABLE_BIT   = 0;
  localparam int CTRL_GND_CHK_BIT  = 1;

  // mode register: bits 3:0 mode, bit 4 keep-assignment digit (0 = keep)
  localparam int MODE_KEEP_BIT     = 4;

  localparam logic [7:0]  FRESET_MAGIC      = 8'h0A;
  localparam logic [7:0]  FAULT_NONE        = 8'h00;
  localparam logic [7:0]  OVERCURRENT_CODE  = 8'h01;

  // brake function assignment: 0 = unassigned, 1..4 = output number
  localparam logic [2:0]  MAP_NONE          = 3'h0;
  localparam logic [2:0]  MAP_FOURTH        = 3'h4;
  localparam logic [3:0]  MODE_RESET        = 4'h0;
  localparam logic [4:0]  MODE_REG_RESET    = 5'h00;

  localparam logic [1:0]  MAX_FAILS         = 2'h3;
  localparam int          LOCKOUT_S         = 60;
  localparam int          CLK_HZ            = 250_000_000;
  localparam longint      LOCKOUT_CYCLES    = longint'(LOCKOUT_S) * CLK_HZ;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } mfbc_bus_t;

  typedef struct packed {
    logic       phase_uv;
    logic       phase_vw;
    logic       phase_wu;
    logic       gnd_u;
    logic       gnd_v;
    logic       gnd_w;
  } mfbc_sense_t;

endpackage

/* hw/mfbc_short_det.sv */
// Purpose: combines short-circuit comparator flags into one trip
// Assumes: sense flags are synchronous levels, high while a short is seen
// Notes:   no dc bus, braking resistor or brake wire sense is taken
`timescale 1ns/1ns
`default_nettype none
module mfbc_short_det (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire mfbc_pkg::mfbc_sense_t sense,
  input  wire logic                 gnd_chk_en,
  output logic                      trip
);
  typedef struct packed {
    logic trip;
  } mfbc_sd_state_t;

  mfbc_sd_state_t s_q;
  mfbc_sd_state_t s_d;

  always_comb begin
    s_d = s_q;
    // phase to phase, always supervised
    s_d.trip = sense.phase_uv | sense.phase_vw | sense.phase_wu; // RULE1
    // phase to ground, strapped off on the smallest variants
    if (gnd_chk_en) begin
      s_d.trip = s_d.trip | sense.gnd_u | sense.gnd_v | sense.gnd_w; // RULE2
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign trip = s_q.trip;
endmodule
`default_nettype wire

/* hw/mfbc_lockout.sv */
// Purpose: counts failed power-stage resets and blocks further ones
// Assumes: fail and success are one-cycle pulses
// Notes:   lockout length is a parameter so simulation can shorten it
`timescale 1ns/1ns
`default_nettype none
module mfbc_lockout #(
  parameter longint LOCK_CYCLES = mfbc_pkg::LOCKOUT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       fail,
  input  wire logic       success,
  output logic            locked,
  output logic [1:0]      fail_cnt
);
  typedef struct packed {
    logic        locked;
    logic [1:0]  cnt;
    logic [39:0] timer;
  } mfbc_lk_state_t;

  mfbc_lk_state_t s_q;
  mfbc_lk_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.locked) begin
      if (s_q.timer == 40'h0) begin
        s_d.locked = 1'b0;
        s_d.cnt    = 2'h0; // RULE14
      end else begin
        s_d.timer = s_q.timer - 40'h1;
      end
    end else if (success) begin
      s_d.cnt = 2'h0; // RULE14
    end else if (fail) begin
      if (s_q.cnt == mfbc_pkg::MAX_FAILS - 2'h1) begin
        s_d.cnt    = mfbc_pkg::MAX_FAILS;
        s_d.locked = 1'b1; // RULE7
        // minus one: the expiry cycle itself counts
        s_d.timer  = LOCK_CYCLES[39:0] - 40'h1;
      end else begin
        s_d.cnt = s_q.cnt + 2'h1; // RULE7
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign locked   = s_q.locked;
  assign fail_cnt = s_q.cnt;
endmodule
`default_nettype wire

/* testbench/mfbc_top_sva.sv */
// Purpose: port-level checker for mfbc_top
// Assumes: one clock domain, NRST async active low
// Notes:   the brake mapping is not visible here, so the bench checks it
`timescale 1ns/1ns
`default_nettype none
module mfbc_top_sva #(
  parameter longint LOCK_CYCLES = 20
) (
  input wire logic                  REF_CLK,
  input wire logic                  NRST,
  input wire logic                  REG_WR,
  input wire logic                  REG_RD,
  input wire logic [3:0]            REG_ADDR,
  input wire logic [31:0]           REG_WDATA,
  input wire logic [31:0]           REG_RDATA,
  input wire mfbc_pkg::mfbc_sense_t SHORT_SENSE,
  input wire logic                  MODE_SWITCH_POSITION_INPUT,
  input wire logic [3:0]            MODE_SWITCH_VALUE,
  input wire logic                  POWER_STAGE_EN,
  input wire logic [3:0]            DIGITAL_OUTPUT,
  input wire logic [7:0]            FAULT_CODE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  logic ph;
  assign ph = |SHORT_SENSE[5:3];
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_trip; ph |-> ##1 !POWER_STAGE_EN; endproperty
  a_trip: assert property (p_trip) else $error("stage on after short");
  property p_fault_set; ph |-> ##2 FAULT_CODE == mfbc_pkg::OVERCURRENT_CODE;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("no fault code");
  property p_en_cause;
    $rose(POWER_STAGE_EN) |-> $past(REG_WR) && $past(REG_WDATA[0])
      && $past(REG_ADDR) == mfbc_pkg::ADDR_CTRL;
  endproperty
  a_en_cause: assert property (p_en_cause) else $error("stage on unasked");
  property p_en_clean; $rose(POWER_STAGE_EN) |-> !$past(ph) && !$past(ph, 2);
  endproperty
  a_en_clean: assert property (p_en_clean) else $error("stage on in short");
  property p_rd_fault;
    REG_RD && REG_ADDR == mfbc_pkg::ADDR_FAULT
      |=> REG_RDATA == {24'h00_0000, $past(FAULT_CODE)};
  endproperty
  a_rd_fault: assert property (p_rd_fault) else $error("fault read wrong");
  property p_rd_idle; !REG_RD |=> REG_RDATA == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_code;
    FAULT_CODE == mfbc_pkg::FAULT_NONE || FAULT_CODE == mfbc_pkg::OVERCURRENT_CODE;
  endproperty
  a_code: assert property (p_code) else $error("bad fault code");
  // a fault with no sensed short would mean an undocumented source trips
  property p_fault_src;
    $rose(FAULT_CODE != 8'h00) |-> $past(SHORT_SENSE, 2) != 6'h00;
  endproperty
  a_fault_src: assert property (p_fault_src) else $error("fault w/o short");
  c_short: cover property (ph ##3 FAULT_CODE == mfbc_pkg::OVERCURRENT_CODE);
  c_enable: cover property ($rose(POWER_STAGE_EN));
  c_rd_fault: cover property (REG_RD && REG_ADDR == mfbc_pkg::ADDR_FAULT);
endmodule
bind mfbc_top mfbc_top_sva #(.LOCK_CYCLES(LOCK_CYCLES)) u_sva (
  .REF_CLK(REF_CLK), .NRST(NRST), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .SHORT_SENSE(SHORT_SENSE),
  .MODE_SWITCH_POSITION_INPUT(MODE_SWITCH_POSITION_INPUT),
  .MODE_SWITCH_VALUE(MODE_SWITCH_VALUE), .POWER_STAGE_EN(POWER_STAGE_EN),
  .DIGITAL_OUTPUT(DIGITAL_OUTPUT), .FAULT_CODE(FAULT_CODE));
`default_nettype wire

/* testbench/mfbc_brake_model.sv */
// Purpose: holding brake hung on one digital output
// Assumes: coil energised (brake released) only while the output is high
// Notes:   an unknown level counts as applied, the safe reading
`timescale 1ns/1ns
`default_nettype none
module mfbc_brake_model (
  input  wire logic brake_cmd,
  output logic      released
);
  assign released = (brake_cmd === 1'b1);
endmodule
`default_nettype wire

/* testbench/mfbc_tb_top.sv */
// Purpose: self-checking bench for mfbc_top
// Assumes: lockout shortened to 20 cycles, ground check fitted
// Notes:   brake model sits on the fourth output
`timescale 1ns/1ns
`default_nettype none
module mfbc_tb_top;
  logic        clk, nrst, wr, rd, msel, pse, released;
  logic [3:0]  addr, mval, dout;
  logic [31:0] wdata, rdata, d;
  logic [5:0]  sense;
  logic [7:0]  fcode;
  int          mismatches, comparisons;
  mfbc_top #(.LOCK_CYCLES(20)) DUT (.REF_CLK(clk), .NRST(nrst),
    .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .SHORT_SENSE(sense), .MODE_SWITCH_POSITION_INPUT(msel),
    .MODE_SWITCH_VALUE(mval), .POWER_STAGE_EN(pse), .DIGITAL_OUTPUT(dout),
    .FAULT_CODE(fcode));
  mfbc_brake_model BRK (.brake_cmd(dout[3]), .released(released));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic chk_o(input logic p, input logic [3:0] o);
    chk("power_stage_en", {31'h0, p}, {31'h0, pse});
    chk("digital_output", {28'h0, o}, {28'h0, dout});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic set_sense(input logic [5:0] v);
    @(posedge clk);
    sense <= v;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rreg(mfbc_pkg::ADDR_MAP);
    chk("map", 32'h4, d);
    rreg(mfbc_pkg::ADDR_FAULT);
    chk("fault_reg", 32'h0, d);
    rreg(4'hF);
    chk("unmapped", 32'h0, d);
    wreg(mfbc_pkg::ADDR_CTRL, 32'h3);
    chk_o(1'b1, 4'h8);
    chk("released", 32'h1, {31'h0, released});
    rreg(mfbc_pkg::ADDR_CTRL);
    chk("ctrl", 32'h3, d);
  endtask
  task automatic t_short;
    for (int i = 0; i < 6; i++) begin
      set_sense(6'h01 << i);
      tick(2);
      chk_o(1'b0, 4'h0);
      tick(1);
      chk("fault", 32'h1, {24'h0, fcode});
      set_sense(6'h00);
      tick(2);
      wreg(mfbc_pkg::ADDR_CTRL, 32'h3);
      chk_o(1'b1, 4'h8);
      tick(1);
      chk("fault", 32'h0, {24'h0, fcode});
    end
  endtask
  task automatic t_lock;
    set_sense(6'h20);
    tick(3);
    repeat (3) wreg(mfbc_pkg::ADDR_CTRL, 32'h3);
    rreg(mfbc_pkg::ADDR_STATUS);
    chk("status", 32'h1F, d);
    set_sense(6'h00);
    tick(2);
    wreg(mfbc_pkg::ADDR_CTRL, 32'h3);
    tick(1);
    chk_o(1'b0, 4'h0);
    rreg(mfbc_pkg::ADDR_STATUS);
    chk("status", 32'h1D, d);
    tick(25);
    rreg(mfbc_pkg::ADDR_STATUS);
    chk("status", 32'h01, d);
    wreg(mfbc_pkg::ADDR_CTRL, 32'h3);
    chk_o(1'b1, 4'h8);
  endtask
  task automatic t_map_mode;
    wreg(mfbc_pkg::ADDR_MAP, 32'h0000_0A01);
    tick(1);
    chk_o(1'b1, 4'hB);
    wreg(mfbc_pkg::ADDR_FRESET, 32'h5);
    tick(1);
    chk_o(1'b1, 4'hB);
    wreg(mfbc_pkg::ADDR_FRESET, {24'h0, mfbc_pkg::FRESET_MAGIC});
    tick(1);
    chk_o(1'b1, 4'h8);
    wreg(mfbc_pkg::ADDR_MAP, 32'h0000_0502);
    wreg(mfbc_pkg::ADDR_MODE, 32'h08);
    tick(1);
    chk_o(1'b1, 4'h7);
    wreg(mfbc_pkg::ADDR_MODE, 32'h11);
    tick(1);
    chk_o(1'b1, 4'h8);
    wreg(mfbc_pkg::ADDR_MODE, 32'h18);
    tick(1);
    chk_o(1'b1, 4'h0);
    rreg(mfbc_pkg::ADDR_MODE);
    chk("mode", 32'h18, d);
    @(posedge clk);
    msel <= 1'b1;
    mval <= 4'h2;
    tick(2);
    chk_o(1'b1, 4'h8);
    rreg(mfbc_pkg::ADDR_MODE);
    chk("mode", 32'h12, d);
    @(posedge clk);
    msel <= 1'b0;
    wreg(mfbc_pkg::ADDR_CTRL, 32'h2);
    tick(1);
    chk_o(1'b0, 4'h0);
    chk("released", 32'h0, {31'h0, released});
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    $display("Error watchdog expected done seen hang");
    report_and_stop();
  end
  initial begin
    {nrst, wr, rd, msel, addr, mval, wdata, sense} = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_short();
    t_lock();
    t_map_mode();
    report_and_stop();
  end
endmodule
`default_nettype wire
